// >>> shared/sr1_pkg.sv
/*
  Constants for the status-one register block: command codes, field positions,
  reset values, register addresses and timing counts.
  Assumes a 20 MHz system clock and a byte-oriented serial command link.
*/
package sr1_pkg;

  // Command codes
  localparam logic [7:0] OPC_NONVOLATILE_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_VOLATILE_WRITE_ENABLE    = 8'h50;
  localparam logic [7:0] OPC_WRITE_DISABLE            = 8'h04;
  localparam logic [7:0] OPC_WRITE_REGISTERS          = 8'h01;
  localparam logic [7:0] OPC_WRITE_ANY_REGISTER       = 8'h71;
  localparam logic [7:0] OPC_READ_ANY_REGISTER        = 8'h65;
  localparam logic [7:0] OPC_READ_STATUS_ONE          = 8'h05;
  localparam logic [7:0] OPC_CLEAR_STATUS             = 8'h30;
  localparam logic [7:0] OPC_SUSPEND                  = 8'h75;
  localparam logic [7:0] OPC_RESET_ARM                = 8'h66;
  localparam logic [7:0] OPC_RESET_GO                 = 8'h99;

  // Field positions in both copies
  localparam int LOCK_POS        = 7;
  localparam int GRANULARITY_POS = 6;
  localparam int ORIGIN_POS      = 5;
  localparam int RANGE_HI_POS    = 4;
  localparam int RANGE_LO_POS    = 2;
  localparam int LATCH_POS       = 1;
  localparam int BUSY_POS        = 0;

  // Factory contents of the default copy
  localparam logic [7:0] DEFAULT_COPY_RESET = 8'h00;

  // Register addresses for the any-register commands
  localparam logic [23:0] ADDR_DEFAULT_COPY = 24'h000000;
  localparam logic [23:0] ADDR_WORKING_COPY = 24'h800000;

  // Frame lengths in link clock edges
  localparam logic [5:0] BITS_OPCODE      = 6'h08;
  localparam logic [5:0] BITS_WRITE_REGS  = 6'h10;
  localparam logic [5:0] BITS_ADDRESS_END = 6'h20;
  localparam logic [5:0] BITS_WRITE_ANY   = 6'h28;

  // Non-volatile write time
  localparam int CLK_PERIOD_NS     = 50;
  localparam int NV_WRITE_TIME_NS  = 400;
  localparam int NV_WRITE_CYC_INT  = (NV_WRITE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : NV_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] NV_WRITE_CYCLES = 8'(NV_WRITE_CYC_INT);

  // Embedded operation states
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_REG_WRITE,
    OP_ARRAY
  } sr1_op_type;

endpackage

// >>> logic/sr1_status_reg.sv
/*
  Status register one of a serial flash: default copy, working copy, write
  enable latch, busy flag, error flags and the serial command front end.
  Assumes the array engine reports start, completion and failures on clk,
  and that chip select stays high at least 200 ns between frames.
*/
// Function
// - Default copy holds lock, granularity, origin and range defaults; range ships zero.
// - Latch and busy default bits are fixed; writes never change them.
// - Lock bit set with protect pin low blocks all locked register writes.
// - Protect pin high permits locked writes; pin affects no other registers.
// - Quad command or quad I/O mode forces internal protect level high.
// - Working lock and origin bits follow writes to their default counterparts.
// - Granularity bit selects 4 kB sectors when set, 64 kB blocks when clear.
// - Origin bit anchors protection at top when clear, bottom when set.
// - Three range bits select the array portion shielded from program and erase.
// - Program, register write or erase starts only while the latch is set.
// - Both write enable commands set the latch; write disable clears it.
// - Latch clears after successful operations; clear-status clears it after failures.
// - Register write data bits 1 and 0 never change the latch or busy flag.
// - Every reset loads the latch from its default bit.
// - While busy only reads, suspend, clear-status and software reset are taken.
// - Suspend taken only during array program or erase.
// - Error flags update during array operations; set errors hold busy until clear-status or a reset.
// - Status read returns the working copy.
// - Working copy writable after volatile enable, default copy after non-volatile enable.
// - Reset copies defaults into working copy; default writes refresh working copy.
// - Error flags are cleared only by clear-status or a reset, untouched by register writes.
`timescale 1ns/1ps

module sr1_status_reg (
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link
  input  wire logic       sck,
  input  wire logic       csN,
  input  wire logic       si,
  output logic            so,
  output logic            soOeN,
  // Pins and interface modes
  input  wire logic       wpN,
  input  wire logic       hwResetN,
  input  wire logic       quadCmdMode,
  input  wire logic       quadIoMode,
  // Array engine
  input  wire logic       arrayStart,
  input  wire logic       arrayDone,
  input  wire logic       programFail,
  input  wire logic       eraseFail,
  // Status and protection state
  output logic            registerLockBit,
  output logic            granularityBit,
  output logic            rangeOriginBit,
  output logic [2:0]      legacyRange,
  output logic            writeEnableLatch,
  output logic            busyFlag,
  output logic            programError,
  output logic            eraseError,
  output logic            registersLocked,
  output logic            writePermit,
  output logic            suspendReq,
  output logic [7:0]      statusOneDefaultCopy
);

  // ---------------- Link clock domain ----------------
  logic [5:0]  bitCntReg;
  logic [5:0]  frameBitsReg;
  logic [6:0]  shiftReg;
  logic [7:0]  opcodeReg;
  logic [7:0]  dataByteReg;
  logic [31:0] tailReg;
  logic        readSelNvReg;
  logic        frameValidReg;
  logic        frameClrReg;
  logic [7:0]  snapWorkReg;
  logic [7:0]  snapDefReg;

  wire logic [5:0] cntNext    = (bitCntReg == 6'h3f) ? bitCntReg : bitCntReg + 6'h01;
  wire logic [7:0] byteIn     = {shiftReg, si};
  wire logic [23:0] readAddr  = {tailReg[22:0], si};
  wire logic readStatus       = (opcodeReg == sr1_pkg::OPC_READ_STATUS_ONE) && (bitCntReg >= sr1_pkg::BITS_OPCODE);
  wire logic readAny          = (opcodeReg == sr1_pkg::OPC_READ_ANY_REGISTER)
                                && (bitCntReg >= sr1_pkg::BITS_ADDRESS_END);
  // Status read shows the working copy
  // default copy out for read-any at its address, else working copy
  wire logic [7:0] outByte    = (readAny && readSelNvReg) ? snapDefReg : snapWorkReg;

  // Bit count restarts with every frame
  always_ff @(posedge sck or posedge csN) begin
    if (csN) begin
      bitCntReg <= 6'h00;
    end else begin
      bitCntReg <= cntNext;
    end
  end

  always_ff @(posedge sck) begin
    shiftReg     <= byteIn[6:0];
    frameBitsReg <= cntNext;
    if (bitCntReg == sr1_pkg::BITS_OPCODE - 6'h01) begin
      opcodeReg <= byteIn;
    end
    if (bitCntReg == sr1_pkg::BITS_WRITE_REGS - 6'h01) begin
      dataByteReg <= byteIn;
    end
    if (bitCntReg >= sr1_pkg::BITS_OPCODE) begin
      tailReg <= {tailReg[30:0], si};
    end
    if (bitCntReg == sr1_pkg::BITS_ADDRESS_END - 6'h01) begin
      readSelNvReg <= (readAddr == sr1_pkg::ADDR_DEFAULT_COPY);
    end
  end

  // Marks a frame with at least one edge; cleared by the system side
  always_ff @(posedge sck or posedge frameClrReg) begin
    if (frameClrReg) begin
      frameValidReg <= 1'b0;
    end else begin
      frameValidReg <= 1'b1;
    end
  end

  // Output shifts on the falling edge, MSB first, byte repeats until the bit count stops at 63, then bit 0 holds
  always_ff @(negedge sck or posedge csN) begin
    if (csN) begin
      so    <= 1'b0;
      soOeN <= 1'b1;
    end else begin
      soOeN <= ~(readStatus | readAny);
      so    <= (readStatus | readAny) ? outByte[~bitCntReg[2:0]] : 1'b0;
    end
  end

  // ---------------- System clock domain ----------------
  logic csSync1Reg;
  logic csSync2Reg;
  logic csPrevReg;
  logic wpSync1Reg;
  logic wpSync2Reg;
  logic hwSync1Reg;
  logic hwSync2Reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      csSync1Reg <= 1'b1;
      csSync2Reg <= 1'b1;
      csPrevReg  <= 1'b1;
      wpSync1Reg <= 1'b1;
      wpSync2Reg <= 1'b1;
      hwSync1Reg <= 1'b1;
      hwSync2Reg <= 1'b1;
    end else begin
      csSync1Reg <= csN;
      csSync2Reg <= csSync1Reg;
      csPrevReg  <= csSync2Reg;
      wpSync1Reg <= wpN;
      wpSync2Reg <= wpSync1Reg;
      hwSync1Reg <= hwResetN;
      hwSync2Reg <= hwSync1Reg;
    end
  end

  logic [7:0]          defReg;
  logic [7:2]          workReg;
  logic                latchReg;
  logic                busyReg;
  logic                volModeReg;
  logic                armReg;
  logic                progErrReg;
  logic                eraseErrReg;
  logic [7:0]          timerReg;
  sr1_pkg::sr1_op_type stateReg;
  logic                lockedReg;
  logic                permitReg;
  logic                suspendReg;

  logic [7:0]          defNext;
  logic [7:2]          workNext;
  logic                latchNext;
  logic                busyNext;
  logic                volModeNext;
  logic                progErrNext;
  logic                eraseErrNext;
  logic [7:0]          timerNext;
  sr1_pkg::sr1_op_type stateNext;

  // Frame decode; frame registers are still while chip select is high
  wire logic frameEnd     = csSync2Reg & ~csPrevReg & frameValidReg;
  wire logic singleByte   = frameEnd && (frameBitsReg == sr1_pkg::BITS_OPCODE);
  wire logic [23:0] wAddr = tailReg[31:8];
  wire logic addrDefault  = (wAddr == sr1_pkg::ADDR_DEFAULT_COPY);
  wire logic addrWorking  = (wAddr == sr1_pkg::ADDR_WORKING_COPY);
  wire logic idleOk       = ~busyReg;
  wire logic cmdNvWren    = singleByte && idleOk && (opcodeReg == sr1_pkg::OPC_NONVOLATILE_WRITE_ENABLE);
  wire logic cmdVolWren   = singleByte && idleOk && (opcodeReg == sr1_pkg::OPC_VOLATILE_WRITE_ENABLE);
  wire logic cmdDisable   = singleByte && idleOk && (opcodeReg == sr1_pkg::OPC_WRITE_DISABLE);
  wire logic cmdClear     = singleByte && (opcodeReg == sr1_pkg::OPC_CLEAR_STATUS);
  wire logic cmdArm       = singleByte && (opcodeReg == sr1_pkg::OPC_RESET_ARM);
  wire logic cmdGo        = singleByte && (opcodeReg == sr1_pkg::OPC_RESET_GO) && armReg;
  wire logic cmdSuspend   = singleByte && (opcodeReg == sr1_pkg::OPC_SUSPEND) && (stateReg == sr1_pkg::OP_ARRAY);
  wire logic cmdWriteRegs = frameEnd && (opcodeReg == sr1_pkg::OPC_WRITE_REGISTERS)
                            && (frameBitsReg >= sr1_pkg::BITS_WRITE_REGS);
  wire logic cmdWriteAny  = frameEnd && (opcodeReg == sr1_pkg::OPC_WRITE_ANY_REGISTER)
                            && (frameBitsReg == sr1_pkg::BITS_WRITE_ANY) && (addrDefault | addrWorking);
  wire logic writeToNv    = cmdWriteRegs ? ~volModeReg : addrDefault;
  wire logic [7:0] wData  = cmdWriteRegs ? dataByteReg : tailReg[7:0];

  wire logic wpInternal   = wpSync2Reg | quadCmdMode | quadIoMode;
  wire logic lockActive   = workReg[sr1_pkg::LOCK_POS] & ~wpInternal;
  wire logic regWriteOk   = (cmdWriteRegs | cmdWriteAny) & latchReg & idleOk & ~lockActive;
  wire logic arrayOk      = arrayStart & latchReg & idleOk;
  wire logic reload       = cmdGo | ~hwSync2Reg;

  always_comb begin
    defNext      = defReg;
    workNext     = workReg;
    latchNext    = latchReg;
    volModeNext  = volModeReg;
    progErrNext  = progErrReg;
    eraseErrNext = eraseErrReg;
    timerNext    = timerReg;
    stateNext    = stateReg;
    unique case (stateReg)
      sr1_pkg::OP_IDLE: begin
        if (arrayOk) begin
          stateNext = sr1_pkg::OP_ARRAY;
        end
      end
      sr1_pkg::OP_REG_WRITE: begin
        timerNext = timerReg - 8'h01;
        if (timerReg == 8'h01) begin
          stateNext = sr1_pkg::OP_IDLE;
          latchNext = 1'b0;
        end
      end
      sr1_pkg::OP_ARRAY: begin
        if (arrayDone) begin
          stateNext = sr1_pkg::OP_IDLE;
          if (!(programFail | eraseFail | progErrReg | eraseErrReg)) begin
            latchNext = 1'b0;
          end
        end
      end
    endcase
    if (cmdNvWren) begin
      latchNext   = 1'b1;
      volModeNext = 1'b0;
    end
    if (cmdVolWren) begin
      latchNext   = 1'b1;
      volModeNext = 1'b1;
    end
    if (cmdDisable) begin
      latchNext = 1'b0;
    end
    // only bits 7 to 2 written
    if (regWriteOk && writeToNv) begin
      defNext[7:2] = wData[7:2];
      workNext     = wData[7:2];
      timerNext    = sr1_pkg::NV_WRITE_CYCLES;
      stateNext    = sr1_pkg::OP_REG_WRITE;
    end
    if (regWriteOk && !writeToNv) begin
      workNext  = wData[7:2];
      latchNext = 1'b0;
    end
    if (cmdClear) begin
      progErrNext  = 1'b0;
      eraseErrNext = 1'b0;
      latchNext    = 1'b0;
    end
    if (stateReg == sr1_pkg::OP_ARRAY) begin
      progErrNext  = progErrNext | programFail;
      eraseErrNext = eraseErrNext | eraseFail;
    end
    if (reload) begin
      workNext     = defReg[7:2];
      latchNext    = defReg[sr1_pkg::LATCH_POS];
      stateNext    = sr1_pkg::OP_IDLE;
      progErrNext  = 1'b0;
      eraseErrNext = 1'b0;
      volModeNext  = 1'b0;
    end
  end

  always_comb begin
    busyNext = (stateNext != sr1_pkg::OP_IDLE) | progErrNext | eraseErrNext;
    if (reload) begin
      busyNext = defReg[sr1_pkg::BUSY_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      defReg      <= sr1_pkg::DEFAULT_COPY_RESET;
      workReg     <= sr1_pkg::DEFAULT_COPY_RESET[7:2];
      latchReg    <= sr1_pkg::DEFAULT_COPY_RESET[sr1_pkg::LATCH_POS];
      busyReg     <= sr1_pkg::DEFAULT_COPY_RESET[sr1_pkg::BUSY_POS];
      volModeReg  <= 1'b0;
      progErrReg  <= 1'b0;
      eraseErrReg <= 1'b0;
      timerReg    <= 8'h00;
      stateReg    <= sr1_pkg::OP_IDLE;
    end else begin
      defReg      <= defNext;
      workReg     <= workNext;
      latchReg    <= latchNext;
      busyReg     <= busyNext;
      volModeReg  <= volModeNext;
      progErrReg  <= progErrNext;
      eraseErrReg <= eraseErrNext;
      timerReg    <= timerNext;
      stateReg    <= stateNext;
    end
  end

  // Reset arming, frame clearing and derived outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      armReg      <= 1'b0;
      frameClrReg <= 1'b1;
      lockedReg   <= 1'b0;
      permitReg   <= 1'b0;
      suspendReg  <= 1'b0;
    end else begin
      armReg      <= frameEnd ? cmdArm : armReg;
      frameClrReg <= frameEnd;
      lockedReg   <= lockActive;
      permitReg   <= latchNext & ~busyNext;
      suspendReg  <= cmdSuspend;
    end
  end

  // Snapshot for the link side, frozen while a frame is open
  always_ff @(posedge clk) begin
    if (rst) begin
      snapWorkReg <= 8'h00;
      snapDefReg  <= 8'h00;
    end else if (csSync2Reg) begin
      snapWorkReg <= {workNext, latchNext, busyNext};
      snapDefReg  <= defNext;
    end
  end

  assign registerLockBit      = workReg[sr1_pkg::LOCK_POS];
  assign granularityBit       = workReg[sr1_pkg::GRANULARITY_POS];
  assign rangeOriginBit       = workReg[sr1_pkg::ORIGIN_POS];
  assign legacyRange          = workReg[sr1_pkg::RANGE_HI_POS:sr1_pkg::RANGE_LO_POS];
  assign writeEnableLatch     = latchReg;
  assign busyFlag             = busyReg;
  assign programError         = progErrReg;
  assign eraseError           = eraseErrReg;
  assign registersLocked      = lockedReg;
  assign writePermit          = permitReg;
  assign suspendReq           = suspendReg;
  assign statusOneDefaultCopy = defReg;

endmodule // sr1_status_reg

// >>> tb/sr1_status_reg_props.sv
/*
  Concurrent checks on the status-one block, seen from its ports only.
  Assumes it is bound onto sr1_status_reg and that rst resets all outputs.
*/
`timescale 1ns/1ps

module sr1_status_reg_props (
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Causes
  input  wire logic       quadCmdMode,
  input  wire logic       quadIoMode,
  input  wire logic       arrayDone,
  input  wire logic       programFail,
  input  wire logic       eraseFail,
  // State
  input  wire logic       writeEnableLatch,
  input  wire logic       busyFlag,
  input  wire logic       programError,
  input  wire logic       eraseError,
  input  wire logic       registersLocked,
  input  wire logic       writePermit,
  input  wire logic       suspendReq,
  input  wire logic [7:0] statusOneDefaultCopy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_permit;
    writePermit == (writeEnableLatch && !busyFlag);
  endproperty
  a_permit: assert property (p_permit)
    else $error("write permit disagrees with latch and busy");

  property p_quad;
    (quadCmdMode || quadIoMode) [*2] |-> !registersLocked;
  endproperty
  a_quad: assert property (p_quad)
    else $error("registers locked in a quad mode");

  property p_fixed;
    statusOneDefaultCopy[1:0] == sr1_pkg::DEFAULT_COPY_RESET[sr1_pkg::LATCH_POS:sr1_pkg::BUSY_POS];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("factory bits of default copy changed");

  property p_latchSet;
    $rose(writeEnableLatch) |-> $past(!busyFlag);
  endproperty
  a_latchSet: assert property (p_latchSet)
    else $error("latch set while busy");

  property p_busyStart;
    $rose(busyFlag) |-> $past(writeEnableLatch);
  endproperty
  a_busyStart: assert property (p_busyStart)
    else $error("operation started without latch");

  property p_errBusy;
    (programError || eraseError) |-> busyFlag;
  endproperty
  a_errBusy: assert property (p_errBusy)
    else $error("error flag set but not busy");

  property p_progErr;
    $rose(programError) |-> $past(programFail && busyFlag);
  endproperty
  a_progErr: assert property (p_progErr)
    else $error("program error without failure");

  property p_eraseErr;
    $rose(eraseError) |-> $past(eraseFail && busyFlag);
  endproperty
  a_eraseErr: assert property (p_eraseErr)
    else $error("erase error without failure");

  property p_done;
    arrayDone && busyFlag && !programError && !eraseError && !programFail && !eraseFail
      |=> !busyFlag && !writeEnableLatch;
  endproperty
  a_done: assert property (p_done)
    else $error("clean completion left busy or latch");

  property p_suspend;
    suspendReq |-> busyFlag ##1 !suspendReq;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspend pulse outside busy or too long");

  c_busy: cover property ($rose(busyFlag));
  c_suspend: cover property (suspendReq);
  c_locked: cover property (registersLocked);
endmodule // sr1_status_reg_props

bind sr1_status_reg sr1_status_reg_props sr1_status_reg_props_i (
  .clk(clk), .rst(rst), .quadCmdMode(quadCmdMode), .quadIoMode(quadIoMode), .arrayDone(arrayDone),
  .programFail(programFail), .eraseFail(eraseFail), .writeEnableLatch(writeEnableLatch),
  .busyFlag(busyFlag), .programError(programError), .eraseError(eraseError),
  .registersLocked(registersLocked), .writePermit(writePermit), .suspendReq(suspendReq),
  .statusOneDefaultCopy(statusOneDefaultCopy)
);

// >>> tb/sr1_host_model.sv
/*
  Host side of the serial link: sends frames MSB first and gathers read data.
  Assumes a 48 ns link clock that stands low between frames.
*/
`timescale 1ns/1ps

module sr1_host_model (
  // Link
  output logic sck,
  output logic csN,
  output logic si,
  input  wire logic so,
  input  wire logic soOeN
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    si  = 1'b0;
  end

  // Frame of n bits; read bits gathered from bit rdAt on
  task automatic xfer(input logic [47:0] d, input int n, input int rdAt, output logic [7:0] rd);
    rd = 8'h00;
    csN = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      si = d[47-i];
      #24 sck = 1'b1;
      if (i >= rdAt) rd = {rd[6:0], soOeN ? 1'bx : so};
      #24 sck = 1'b0;
    end
    #24 csN = 1'b1;
    // Released line shows no stale value
    si = ~si;
    #300;
  endtask
endmodule // sr1_host_model

// >>> tb/tb_top.sv
/*
  Self-checking bench for the status-one block against a reference model.
  Assumes the package, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] NVWE = sr1_pkg::OPC_NONVOLATILE_WRITE_ENABLE;
  localparam logic [7:0] VWE  = sr1_pkg::OPC_VOLATILE_WRITE_ENABLE;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wpN = 1'b1;
  logic       hwResetN = 1'b1;
  logic       quadCmdMode = 1'b0;
  logic       quadIoMode = 1'b0;
  logic       arrayStart = 1'b0;
  logic       arrayDone = 1'b0;
  logic       programFail = 1'b0;
  logic       eraseFail = 1'b0;
  wire logic  sck, csN, si, so, soOeN;
  wire logic  registerLockBit, granularityBit, rangeOriginBit, writeEnableLatch, busyFlag;
  wire logic  programError, eraseError, registersLocked, writePermit, suspendReq;
  wire logic [2:0] legacyRange;
  wire logic [7:0] statusOneDefaultCopy;
  int         mW, mD, mL, mB, mP, mE, sus, errorCnt, nTests;
  logic [7:0] lf = 8'h48;
  logic [7:0] d, rd;

  always #25 clk = ~clk;
  always @(posedge clk) if (suspendReq === 1'b1) sus++;

  sr1_status_reg sr1_status_reg_i (
    .clk(clk), .rst(rst), .sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN),
    .wpN(wpN), .hwResetN(hwResetN), .quadCmdMode(quadCmdMode), .quadIoMode(quadIoMode),
    .arrayStart(arrayStart), .arrayDone(arrayDone), .programFail(programFail), .eraseFail(eraseFail),
    .registerLockBit(registerLockBit), .granularityBit(granularityBit), .rangeOriginBit(rangeOriginBit),
    .legacyRange(legacyRange), .writeEnableLatch(writeEnableLatch), .busyFlag(busyFlag),
    .programError(programError), .eraseError(eraseError), .registersLocked(registersLocked),
    .writePermit(writePermit), .suspendReq(suspendReq), .statusOneDefaultCopy(statusOneDefaultCopy)
  );
  sr1_host_model sr1_host_model_i (.sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chkAll();
    check({registerLockBit, granularityBit, rangeOriginBit, legacyRange, 2'b00}, 8'(mW));
    check(statusOneDefaultCopy, 8'(mD));
    check({6'h00, writeEnableLatch, busyFlag}, 8'(mL * 2 + mB));
    check({6'h00, programError, eraseError}, 8'(mP * 2 + mE));
    check({7'h00, writePermit}, 8'(mL == 1 && mB == 0));
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    sr1_host_model_i.xfer({op, 40'h0}, 8, 99, r);
  endtask

  task automatic write_registers_cmd(input logic [7:0] v);
    logic [7:0] r;
    sr1_host_model_i.xfer({8'h01, v, 32'h0}, 16, 99, r);
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    while (busyFlag !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k == 100) begin
      errorCnt++;
      finishTest();
    end
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chkAll();
    $display("reset test done");
    lf = lfsr(lf);
    d = lf & 8'h7c;
    cmd(VWE);
    mL = 1;
    chkAll();
    write_registers_cmd(d | 8'h03);
    mW = d;
    mL = 0;
    chkAll();
    sr1_host_model_i.xfer({sr1_pkg::OPC_READ_STATUS_ONE, 40'h0}, 16, 8, rd);
    check(rd, 8'(mW + mL * 2 + mB));
    $display("volatile write test done");
    lf = lfsr(lf);
    d = lf & 8'h7c;
    cmd(NVWE);
    write_registers_cmd(d | 8'h03);
    check({7'h00, busyFlag}, 8'h01);
    waitIdle();
    mD = d;
    mW = d;
    chkAll();
    sr1_host_model_i.xfer({sr1_pkg::OPC_READ_ANY_REGISTER, sr1_pkg::ADDR_DEFAULT_COPY, 16'h0}, 40, 32, rd);
    check(rd, 8'(mD));
    cmd(NVWE);
    cmd(sr1_pkg::OPC_WRITE_DISABLE);
    chkAll();
    $display("default write test done");
    cmd(VWE);
    sr1_host_model_i.xfer({8'h71, sr1_pkg::ADDR_WORKING_COPY, 8'h9c, 8'h00}, 40, 99, rd);
    mW = 8'h9c;
    for (int q = 0; q < 4; q++) begin
      @(negedge clk);
      wpN = (q == 3);
      quadCmdMode = (q == 1);
      quadIoMode = (q == 2);
      repeat (5) @(negedge clk);
      check({7'h00, registersLocked}, 8'(q == 0));
      cmd(VWE);
      write_registers_cmd(8'h80 | 8'(q << 2));
      mL = (q == 0);
      if (q != 0) mW = 8'h80 | (q << 2);
      chkAll();
    end
    $display("lock test done");
    for (int f = 0; f < 3; f++) begin
      cmd(NVWE);
      @(negedge clk) arrayStart = 1'b1;
      @(negedge clk) arrayStart = 1'b0;
      programFail = (f == 1);
      eraseFail = (f == 2);
      @(negedge clk) programFail = 1'b0;
      eraseFail = 1'b0;
      sus = 0;
      cmd(sr1_pkg::OPC_WRITE_DISABLE);
      cmd(sr1_pkg::OPC_SUSPEND);
      check(8'(sus), 8'h01);
      mL = 1;
      mB = 1;
      mP = (f == 1);
      mE = (f == 2);
      chkAll();
      @(negedge clk) arrayDone = 1'b1;
      @(negedge clk) arrayDone = 1'b0;
      repeat (2) @(negedge clk);
      mB = (f != 0);
      mL = (f != 0);
      chkAll();
      cmd(sr1_pkg::OPC_CLEAR_STATUS);
      mB = 0;
      mL = 0;
      mP = 0;
      mE = 0;
      chkAll();
    end
    sus = 0;
    cmd(sr1_pkg::OPC_SUSPEND);
    check(8'(sus), 8'h00);
    $display("array test done");
    cmd(VWE);
    @(negedge clk) hwResetN = 1'b0;
    repeat (4) @(negedge clk);
    hwResetN = 1'b1;
    repeat (4) @(negedge clk);
    mW = mD;
    chkAll();
    cmd(VWE);
    write_registers_cmd(8'h10);
    cmd(VWE);
    cmd(sr1_pkg::OPC_RESET_ARM);
    cmd(sr1_pkg::OPC_RESET_GO);
    chkAll();
    $display("reset pin and software reset tests done");
    finishTest();
  end
endmodule // tb_top
